/* shared/rmx_pkg.sv */
// constants, enumerations and carriers of the real-mode exception and debug unit
package rmx_pkg;
  // clock and start-up delay after reset release
  localparam int MCLK_PERIOD_NS = 40;
  localparam int DOUBLE_FREQ_CLOCK_PERIOD_NS = MCLK_PERIOD_NS / 2; // double_freq_clock runs twice mclk
  localparam int START_DOUBLE_FREQ_CLOCK_MIN = 350;
  localparam int START_DOUBLE_FREQ_CLOCK_MAX = 450;
  localparam int START_MIN_NS = START_DOUBLE_FREQ_CLOCK_MIN * DOUBLE_FREQ_CLOCK_PERIOD_NS;
  localparam int START_MAX_NS = START_DOUBLE_FREQ_CLOCK_MAX * DOUBLE_FREQ_CLOCK_PERIOD_NS;
  localparam int START_CYCLES = (START_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int START_MAX_CYCLES = START_MAX_NS / MCLK_PERIOD_NS;
  localparam int START_CNT_W = 9;

  // register byte offsets
  localparam logic [7:0] ADR_BP0 = 8'h00;
  localparam logic [7:0] ADR_BP1 = 8'h04;
  localparam logic [7:0] ADR_BP2 = 8'h08;
  localparam logic [7:0] ADR_BP3 = 8'h0c;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [7:0] ADR_FLAGS = 8'h18;
  localparam logic [7:0] ADR_LIMIT = 8'h1c;
  localparam logic [7:0] ADR_STATE = 8'h20;

  // field positions
  localparam int BP_NUM = 4;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_W = 12;
  localparam int STAT_STEP_BIT = 4;
  localparam int STAT_W = 5;
  localparam int FLAG_STEP_BIT = 8;
  localparam int FLAG_IE_BIT = 9;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [15:0] FLAGS_RST = 16'h0002;
  localparam logic [15:0] LIMIT_RST = 16'h03ff;
  localparam logic [19:0] BP_ADDR_RST = 20'h00000;

  // vectors and fixed figures
  localparam logic [7:0] VEC_STEP = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BRK = 8'h03;
  localparam logic [7:0] VEC_LOCK = 8'h06;
  localparam logic [7:0] VEC_DBL = 8'h08;
  localparam logic [7:0] VEC_STK = 8'h0c;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] OP_BRK = 8'hcc;
  localparam logic [31:0] SEG_LAST = 32'h0000ffff;
  localparam logic [15:0] NMI_LIMIT_MIN = 16'h000f;
  localparam logic [15:0] NMI_SP_MIN = 16'h0005;

  typedef enum logic [1:0] {
    BP_EXEC = 2'b00,
    BP_WRITE = 2'b01,
    BP_NONE = 2'b10,
    BP_RW = 2'b11
  } rmx_bp_e;

  typedef enum logic [2:0] {
    SEG_CS = 3'b000,
    SEG_DS = 3'b001,
    SEG_ES = 3'b010,
    SEG_FS = 3'b011,
    SEG_GS = 3'b100,
    SEG_SS = 3'b101
  } rmx_seg_e;

  typedef enum logic [2:0] {
    LK_BIT = 3'b000,
    LK_EXCHANGE_OP = 3'b001,
    LK_ALU = 3'b010,
    LK_UNARY = 3'b011,
    LK_OTHER = 3'b100
  } rmx_lock_e;

  typedef enum logic [1:0] {
    RUN_WAIT = 2'b00,
    RUN_GO = 2'b01,
    RUN_HALT = 2'b10,
    RUN_SHUT = 2'b11
  } rmx_run_e;

  typedef struct packed {
    logic valid;
    logic fetch;
    rmx_seg_e seg_kind;
    logic [15:0] seg;
    logic [31:0] off;
    logic word;
    logic write;
  } rmx_mem_s;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic halt_op;
    logic push_op;
    logic [15:0] sp;
    logic [2:0] push_bytes;
  } rmx_retire_s;

  typedef struct packed {
    logic valid;
    logic prefix;
    rmx_lock_e cls;
    logic dest_mem;
    logic rep;
  } rmx_lock_s;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic ret_next;
    logic [19:0] vec_addr;
  } rmx_exc_s;
endpackage

/* src/rmx_unit.sv */
// real-mode exception, debug breakpoint, halt/shutdown and bus-lock control
`timescale 1ns/1ns
module rmx_unit
  import rmx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rmx_retire_s retire,
  input wire rmx_mem_s mem_req,
  input wire rmx_lock_s lock_req,
  input wire logic rmw_read,
  input wire logic rmw_done,
  input wire logic [15:0] stack_pointer,
  input wire logic [7:0] intr_vector,
  input wire logic nmi_pin,
  input wire logic intr_pin,
  input wire logic float_request_pin_b,
  output rmx_exc_s exc,
  output logic [19:0] phys_addr,
  output logic addr_valid,
  output logic fetch_enable,
  output logic halted,
  output logic shutdown,
  output logic bus_lock,
  output logic op_size_32
);

  // software-visible state
  logic [19:0] breakpoint_address_regs [BP_NUM];
  logic [CTRL_W-1:0] breakpoint_control_reg;
  logic [STAT_W-1:0] breakpoint_status_reg;
  logic [15:0] flags_register;
  logic [15:0] table_limit;

  // block state
  rmx_run_e run;
  rmx_run_e next_run;
  logic [START_CNT_W-1:0] start_cnt;
  logic nmi_pend;
  logic dbp_pend;
  logic lock_armed;

  // pin synchronisers: s1 feeds only s2, levels move once s2 and s3 agree
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_lvl;
  logic nmi_lvl_d;
  wire [2:0] pin_raw = {~float_request_pin_b, intr_pin, nmi_pin};
  wire nmi_lvl = pin_lvl[0];
  wire intr_lvl = pin_lvl[1];
  wire float_lvl = pin_lvl[2];
  wire nmi_rise = nmi_lvl & ~nmi_lvl_d;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      nmi_lvl_d <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      nmi_lvl_d <= nmi_lvl;
    end
  end

  // accept a change only when the last two stages match, filtering one-cycle glitches
  for (genvar p = 0; p < 3; p++) begin : g_pin
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        pin_lvl[p] <= 1'b0;
      end else if (pin_s2[p] == pin_s3[p]) begin
        pin_lvl[p] <= pin_s3[p];
      end
    end
  end

  // run-state qualifiers
  wire go = run == RUN_GO;
  wire ret_go = go & retire.valid;
  wire mem_go = go & mem_req.valid;
  wire step_on = flags_register[FLAG_STEP_BIT];
  wire ie_on = flags_register[FLAG_IE_BIT];

  // real-mode address: segment times sixteen plus low offset, carry past 20 bits dropped
  wire [19:0] phys_c = {mem_req.seg, 4'h0} + {4'h0, mem_req.off[15:0]};

  // 64K segment overrun, word straddling ffff included
  wire past_end = mem_req.off > SEG_LAST;
  wire word_wrap = mem_req.word & (mem_req.off == SEG_LAST);
  wire seg_fault = mem_go & (past_end | word_wrap);
  wire stk_fault = seg_fault & (mem_req.seg_kind == SEG_SS);

  // breakpoint comparators, one per address register
  logic [BP_NUM-1:0] hit_x;
  logic [BP_NUM-1:0] hit_d;
  for (genvar i = 0; i < BP_NUM; i++) begin : g_bp
    wire [1:0] bp_type = breakpoint_control_reg[CTRL_TYPE_LSB + 2*i +: 2];
    wire bp_en = breakpoint_control_reg[i];
    wire bp_eq = breakpoint_address_regs[i] == phys_c;
    wire wr_match = (bp_type == BP_WRITE) & mem_req.write;
    assign hit_x[i] = mem_go & mem_req.fetch & bp_en & bp_eq & (bp_type == BP_EXEC);
    assign hit_d[i] = mem_go & ~mem_req.fetch & bp_en & bp_eq & (wr_match | bp_type == BP_RW);
  end

  // lock legality: form only, never privilege
  wire lock_form_ok = ((lock_req.cls == LK_BIT) | (lock_req.cls == LK_ALU)
                      | (lock_req.cls == LK_UNARY) | (lock_req.cls == LK_EXCHANGE_OP))
                      & lock_req.dest_mem;
  wire lock_ok = lock_form_ok & ~lock_req.rep;
  wire lock_seen = go & lock_req.valid & lock_req.prefix;
  wire lock_bad = lock_seen & ~lock_ok;

  // stack wrap with odd pointer is unrecoverable
  wire stack_wrap = ret_go & retire.push_op & retire.sp[0]
                    & (retire.sp < {13'h0000, retire.push_bytes});

  wire nmi_ok = (table_limit >= NMI_LIMIT_MIN) & (stack_pointer > NMI_SP_MIN);
  wire halt_state = run == RUN_HALT;
  wire shut_state = run == RUN_SHUT;
  wire boundary = ret_go | halt_state;

  // one candidate vector per cycle, faults ahead of traps ahead of interrupts
  logic cand_v;
  logic [7:0] cand;
  logic cand_next;
  logic sel_nmi;
  always_comb begin
    cand_v = 1'b0;
    cand = 8'h00;
    cand_next = 1'b0;
    sel_nmi = 1'b0;
    if (lock_bad) begin
      cand_v = 1'b1;
      cand = VEC_LOCK;
    end else if (seg_fault) begin
      cand_v = 1'b1;
      cand = stk_fault ? VEC_STK : VEC_GP;
    end else if (|hit_x) begin
      cand_v = 1'b1;
      cand = VEC_STEP;
    end else if (ret_go & (retire.opcode == OP_BRK)) begin
      cand_v = 1'b1;
      cand = VEC_BRK;
      cand_next = 1'b1;
    end else if (ret_go & (step_on | dbp_pend | (|hit_d))) begin
      cand_v = 1'b1;
      cand = VEC_STEP;
      cand_next = 1'b1;
    end else if ((boundary | (shut_state & nmi_ok)) & nmi_pend) begin
      cand_v = 1'b1;
      cand = VEC_NMI;
      cand_next = 1'b1;
      sel_nmi = 1'b1;
    end else if (boundary & intr_lvl & ie_on) begin
      cand_v = 1'b1;
      cand = intr_vector;
      cand_next = 1'b1;
    end
  end

  // table limit check: entry ends at 4n+3
  wire [15:0] cand_end = {6'h00, cand, 2'b11};
  wire [15:0] dbl_end = {6'h00, VEC_DBL, 2'b11};
  wire cand_out = cand_end > table_limit;
  wire dbl_out = dbl_end > table_limit;
  wire fatal_vec = (cand == VEC_DBL) | (cand == VEC_GP);
  wire to_shut = (cand_v & cand_out & (fatal_vec | dbl_out)) | stack_wrap;
  wire deliver = cand_v & ~to_shut;
  wire [7:0] final_vec = cand_out ? VEC_DBL : cand;
  wire final_next = cand_out ? 1'b0 : cand_next;

  // run sequencing: start delay, halt, shutdown
  wire start_done = start_cnt == START_CNT_W'(START_CYCLES - 1);
  always_comb begin
    next_run = run;
    unique case (run)
      RUN_WAIT: begin
        if (start_done) begin
          next_run = RUN_GO;
        end
      end
      RUN_GO: begin
        if (to_shut) begin
          next_run = RUN_SHUT;
        end else if (ret_go & retire.halt_op & ~cand_v) begin
          next_run = RUN_HALT;
        end
      end
      RUN_HALT: begin
        if (to_shut) begin
          next_run = RUN_SHUT;
        end else if (deliver | float_lvl) begin
          next_run = RUN_GO;
        end
      end
      RUN_SHUT: begin
        if (deliver) begin
          next_run = RUN_GO;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run <= RUN_WAIT;
      start_cnt <= '0;
    end else begin
      run <= next_run;
      start_cnt <= start_done ? start_cnt : start_cnt + 1'b1;
    end
  end

  // nmi edge pends until taken, data hit until the next retirement; refused shutdown nmi dropped; new event wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_pend <= 1'b0;
      dbp_pend <= 1'b0;
    end else begin
      nmi_pend <= nmi_rise | (nmi_pend & ~(sel_nmi & deliver) & ~(shut_state & ~nmi_ok));
      dbp_pend <= (|hit_d) | (dbp_pend & ~ret_go);
    end
  end

  // exception request and address outputs, registered
  wire [19:0] vec_addr_c = {10'h000, final_vec, 2'b00};
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      exc <= '0;
      phys_addr <= 20'h00000;
      addr_valid <= 1'b0;
    end else begin
      exc.valid <= deliver;
      exc.vector <= final_vec;
      exc.ret_next <= final_next;
      exc.vec_addr <= vec_addr_c;
      phys_addr <= phys_c;
      addr_valid <= mem_go & ~seg_fault;
    end
  end

  // visible run status; fetch only while running
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_enable <= 1'b0;
      halted <= 1'b0;
      shutdown <= 1'b0;
      op_size_32 <= 1'b0;
    end else begin
      fetch_enable <= next_run == RUN_GO;
      halted <= next_run == RUN_HALT;
      shutdown <= next_run == RUN_SHUT;
      op_size_32 <= 1'b0;
    end
  end

  // lock held across the locked read and write so arbiters keep others off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lock_armed <= 1'b0;
      bus_lock <= 1'b0;
    end else begin
      if (lock_seen) begin
        lock_armed <= lock_ok;
      end else if (rmw_done) begin
        lock_armed <= 1'b0;
      end
      if (rmw_read & lock_armed) begin
        bus_lock <= 1'b1;
      end else if (rmw_done) begin
        bus_lock <= 1'b0;
      end
    end
  end

  // wishbone decode; one wait state, ack for one cycle
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire hit_ctrl = wb_adr_i == ADR_CTRL;
  wire hit_stat = wb_adr_i == ADR_STAT;
  wire hit_flags = wb_adr_i == ADR_FLAGS;
  wire hit_limit = wb_adr_i == ADR_LIMIT;
  wire [3:0] hit_bp = {wb_adr_i == ADR_BP3, wb_adr_i == ADR_BP2,
                       wb_adr_i == ADR_BP1, wb_adr_i == ADR_BP0};

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] ctrl_new = lane_merge({20'h00000, breakpoint_control_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] flags_new = lane_merge({16'h0000, flags_register}, wb_dat_i, wb_sel_i);
  wire [31:0] limit_new = lane_merge({16'h0000, table_limit}, wb_dat_i, wb_sel_i);
  wire [STAT_W-1:0] stat_clr = (wb_wr & hit_stat & wb_sel_i[0]) ? wb_dat_i[STAT_W-1:0]
                                                                 : {STAT_W{1'b0}};
  wire [STAT_W-1:0] stat_set = {ret_go & step_on, hit_x | hit_d};

  // breakpoint address registers
  for (genvar r = 0; r < BP_NUM; r++) begin : g_bpreg
    wire [31:0] bp_new = lane_merge({12'h000, breakpoint_address_regs[r]}, wb_dat_i, wb_sel_i);
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        breakpoint_address_regs[r] <= BP_ADDR_RST;
      end else if (wb_wr & hit_bp[r]) begin
        breakpoint_address_regs[r] <= bp_new[19:0];
      end
    end
  end

  // control, status, flags and limit; status bits are write-one-to-clear, hits win
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      breakpoint_control_reg <= CTRL_RST;
      breakpoint_status_reg <= STAT_RST;
      flags_register <= FLAGS_RST;
      table_limit <= LIMIT_RST;
    end else begin
      if (wb_wr & hit_ctrl) begin
        breakpoint_control_reg <= ctrl_new[CTRL_W-1:0];
      end
      breakpoint_status_reg <= stat_set | (breakpoint_status_reg & ~stat_clr);
      if (wb_wr & hit_flags) begin
        flags_register <= flags_new[15:0];
      end
      if (wb_wr & hit_limit) begin
        table_limit <= limit_new[15:0];
      end
    end
  end

  // read mux; unmapped offsets read zero and still ack
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    for (int k = 0; k < BP_NUM; k++) begin
      if (hit_bp[k]) begin
        rd_mux = {12'h000, breakpoint_address_regs[k]};
      end
    end
    if (hit_ctrl) begin
      rd_mux = {20'h00000, breakpoint_control_reg};
    end else if (hit_stat) begin
      rd_mux = {27'h0000000, breakpoint_status_reg};
    end else if (hit_flags) begin
      rd_mux = {16'h0000, flags_register};
    end else if (hit_limit) begin
      rd_mux = {16'h0000, table_limit};
    end else if (wb_adr_i == ADR_STATE) begin
      rd_mux = {27'h0000000, lock_armed, bus_lock, nmi_pend, run};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h00000000;
    end
  end

endmodule // rmx_unit

/* test/rmx_unit_asserts.sv */
// port checker for the real-mode exception and debug unit
`timescale 1ns/1ns
module rmx_unit_asserts
  import rmx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire rmx_retire_s retire,
  input wire rmx_mem_s mem_req,
  input wire rmx_lock_s lock_req,
  input wire logic rmw_done,
  input wire rmx_exc_s exc,
  input wire logic [19:0] phys_addr,
  input wire logic addr_valid,
  input wire logic fetch_enable,
  input wire logic halted,
  input wire logic bus_lock,
  input wire logic op_size_32
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // edges since release; frozen once the core first runs, so halt exits do not count
  int n_edge;
  logic started;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      n_edge <= 0;
      started <= 1'b0;
    end else if (!started) begin
      n_edge <= n_edge + 1;
      started <= fetch_enable;
    end
  end

  // request steps named for the ack and halt-entry properties
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence halt_go;
    fetch_enable && retire.valid && retire.halt_op;
  endsequence

  a_start_quiet: assert property (
    !started |-> !exc.valid && !addr_valid && (!fetch_enable || n_edge == START_CYCLES))
    else $error("core active before its start edge");
  a_ack_next: assert property (wb_req |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_size_16: assert property (!op_size_32)
    else $error("wide operand size outside an override");
  a_vec_addr: assert property (exc.valid |-> exc.vec_addr == {10'h000, exc.vector, 2'b00})
    else $error("vector address not four times the vector");
  a_no_real: assert property (exc.valid |-> !(exc.vector inside {8'h0a, 8'h0b, 8'h0e}))
    else $error("vector raised that real mode never raises");
  a_phys_form: assert property (mem_req.valid |=>
    phys_addr == {$past(mem_req.seg), 4'h0} + $past(mem_req.off[15:0]))
    else $error("physical address not segment times sixteen plus offset");
  a_gp_overrun: assert property (fetch_enable && mem_req.valid && mem_req.word &&
    mem_req.off == 32'hffff && mem_req.seg_kind != SEG_SS && !lock_req.valid |=>
    exc.valid && exc.vector == VEC_GP && !exc.ret_next && !addr_valid)
    else $error("word at segment end did not fault");
  a_lock_bad: assert property (fetch_enable && lock_req.valid && lock_req.prefix &&
    (lock_req.cls == LK_OTHER || lock_req.rep) |=> exc.valid && exc.vector == VEC_LOCK)
    else $error("lock on a barred form not refused");
  a_lock_hold: assert property (bus_lock |=> bus_lock == !$past(rmw_done))
    else $error("bus lock dropped early or held past the write");
  a_halt_enter: assert property (halt_go |=> halted && !fetch_enable)
    else $error("halt did not stop the core");
endmodule // rmx_unit_asserts

bind rmx_unit rmx_unit_asserts chk (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .retire(retire), .mem_req(mem_req), .lock_req(lock_req),
  .rmw_done(rmw_done), .exc(exc), .phys_addr(phys_addr), .addr_valid(addr_valid),
  .fetch_enable(fetch_enable), .halted(halted), .bus_lock(bus_lock),
  .op_size_32(op_size_32));

/* test/rmx_sys_model.sv */
// far side: interrupt sources and the memory half of a locked cycle
`timescale 1ns/1ns
module rmx_sys_model (
  input wire logic mclk,
  input wire logic lock_go,
  input wire logic [3:0] span,
  input wire logic nmi_req,
  input wire logic intr_req,
  input wire logic flt_req,
  output logic rmw_read,
  output logic rmw_done,
  output logic nmi_pin,
  output logic intr_pin,
  output logic float_request_pin_b
);
  // pins are asynchronous; the unit synchronises them itself
  assign nmi_pin = nmi_req;
  assign intr_pin = intr_req;
  assign float_request_pin_b = !flt_req; // active low request

  // locked read, operand held span cycles (1 = prompt, larger = slow), then write back
  initial begin
    rmw_read = 1'b0;
    rmw_done = 1'b0;
    forever begin
      @(posedge mclk);
      if (lock_go) begin
        rmw_read <= 1'b1;
        @(posedge mclk);
        rmw_read <= 1'b0;
        repeat (span - 1) @(posedge mclk);
        rmw_done <= 1'b1;
        @(posedge mclk);
        rmw_done <= 1'b0;
      end
    end
  end
endmodule // rmx_sys_model

/* test/rmx_unit_tb.sv */
// self-checking bench for the real-mode exception and debug unit
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module rmx_unit_tb
  import rmx_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack, rmw_read, rmw_done, nmi, intr, flt_b;
  rmx_retire_s retire = '0;
  rmx_mem_s mem_req = '0;
  rmx_lock_s lock_req = '0;
  logic [15:0] sp = 16'h0100;
  logic [7:0] ivec = 8'h20;
  rmx_exc_s exc;
  logic [19:0] phys;
  logic av, fe, halted, shut, blk, os32;
  logic lock_go = 1'b0, nmi_req = 1'b0, intr_req = 1'b0, flt_req = 1'b0;
  logic [3:0] span = 4'h3;
  logic [8:0] e;
  logic [8:0] expq[$];
  logic [7:0] ra[6] = '{ADR_CTRL, ADR_STAT, ADR_FLAGS, ADR_LIMIT, ADR_BP3, ADR_STATE};
  logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h2, 32'h3ff, 32'h0, 32'h1};
  int errors = 0, n_tests = 0;

  always #20 mclk = ~mclk;

  rmx_unit uut (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .retire(retire), .mem_req(mem_req), .lock_req(lock_req), .rmw_read(rmw_read),
    .rmw_done(rmw_done), .stack_pointer(sp), .intr_vector(ivec), .nmi_pin(nmi),
    .intr_pin(intr), .float_request_pin_b(flt_b), .exc(exc), .phys_addr(phys),
    .addr_valid(av), .fetch_enable(fe), .halted(halted), .shutdown(shut),
    .bus_lock(blk), .op_size_32(os32));
  rmx_sys_model sys (
    .mclk(mclk), .lock_go(lock_go), .span(span), .nmi_req(nmi_req), .intr_req(intr_req),
    .flt_req(flt_req), .rmw_read(rmw_read), .rmw_done(rmw_done), .nmi_pin(nmi),
    .intr_pin(intr), .float_request_pin_b(flt_b));

  // reference model: each exception pulse must match the oldest expected one
  always @(negedge mclk) begin
    if (exc.valid === 1'b1) begin
      e = expq.size() ? expq.pop_front() : 9'h1ff;
      `CHK("exception", e, {exc.ret_next, exc.vector})
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tmo();
    errors++;
    conclude();
  endtask

  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1) break;
    end
    if (i == 20) tmo();
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK("register read", x, q)
  endtask

  // edges from release until the core runs
  task automatic st();
    int i;
    for (i = 1; i <= 300; i++) begin
      @(posedge mclk);
      if (fe === 1'b1) break;
    end
    if (i > 300) tmo();
    `CHK("start edges", START_CYCLES + 1, i)
  endtask

  task automatic wt(input bit w, input logic v);
    int i;
    for (i = 0; i < 40 && (w ? shut : halted) !== v; i++) @(negedge mclk);
    if (i == 40) tmo();
  endtask

  // one memory access with its expected fault and address
  task automatic mop(input rmx_seg_e k, input logic [15:0] s, input logic [31:0] o,
                     input logic w, input logic f, input logic bp);
    logic ov;
    logic [19:0] pa;
    ov = o > 32'hffff || (w && o == 32'hffff);
    pa = {s, 4'h0} + o[15:0];
    if (ov) expq.push_back({1'b0, k == SEG_SS ? VEC_STK : VEC_GP});
    else if (bp) expq.push_back({1'b0, VEC_STEP});
    @(posedge mclk);
    mem_req <= '{1'b1, f, k, s, o, w, !f};
    @(posedge mclk);
    mem_req.valid <= 1'b0;
    @(negedge mclk);
    `CHK("physical address", pa, phys)
    `CHK("address accepted", !ov, av)
  endtask

  task automatic rt(input logic [7:0] op, input logic h, input logic p);
    @(posedge mclk);
    retire <= '{1'b1, op, h, p, sp, 3'h2};
    @(posedge mclk);
    retire.valid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic lk(input rmx_lock_e c, input logic r);
    if (c == LK_OTHER || r) expq.push_back({1'b0, VEC_LOCK});
    @(posedge mclk);
    lock_req <= '{1'b1, 1'b1, c, 1'b1, r};
    @(posedge mclk);
    lock_req.valid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic np();
    @(posedge mclk) nmi_req <= 1'b1;
    repeat (6) @(posedge mclk);
    nmi_req <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  // main sequence
  initial begin
    int i;
    void'($urandom(32'he453));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    st();
    foreach (ra[j]) rd(ra[j], rv[j]);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    $display("test reset ended, mismatches %0d", errors);
    for (int k = 0; k < 24; k++) begin
      mop(rmx_seg_e'(k % 3 == 0 ? 5 : k % 3), 16'($urandom),
          k == 4 ? 32'h10000 : k < 4 ? 32'hffff : 32'($urandom % 32'h10000),
          k < 4 || 1'($urandom), 1'b0, 1'b0);
    end
    $display("test addressing ended, mismatches %0d", errors);
    expq.push_back({1'b1, VEC_BRK});
    rt(OP_BRK, 1'b0, 1'b0);
    wr(ADR_FLAGS, 32'h102);
    expq.push_back({1'b1, VEC_STEP});
    rt(8'h90, 1'b0, 1'b0);
    rd(ADR_STAT, 32'h10);
    wr(ADR_FLAGS, 32'h2);
    wr(ADR_STAT, 32'h1f);
    for (int b = 0; b < BP_NUM; b++) begin
      wr(ADR_BP0 + 8'(4 * b), 32'h01230 + 32'(b));
      mop(SEG_CS, 16'h0123, 32'(b), 1'b0, 1'b1, 1'b0);
      wr(ADR_CTRL, 32'h1 << b);
      mop(SEG_CS, 16'h0123, 32'(b), 1'b0, 1'b1, 1'b1);
      rd(ADR_STAT, 32'h1 << b);
      wr(ADR_STAT, 32'h1f);
    end
    wr(ADR_CTRL, 32'h11);
    mop(SEG_DS, 16'h0123, 32'h0, 1'b0, 1'b0, 1'b0);
    expq.push_back({1'b1, VEC_STEP});
    rt(8'h90, 1'b0, 1'b0);
    rd(ADR_STAT, 32'h1);
    wr(ADR_CTRL, 32'h0);
    $display("test debug ended, mismatches %0d", errors);
    for (int c = 0; c < 5; c++) lk(rmx_lock_e'(c), 1'b0);
    lk(LK_ALU, 1'b1);
    span <= 4'(1 + $urandom % 6);
    lk(LK_EXCHANGE_OP, 1'b0);
    @(posedge mclk) lock_go <= 1'b1;
    @(posedge mclk) lock_go <= 1'b0;
    i = 0;
    repeat (20) begin
      @(negedge mclk);
      i += int'(blk);
    end
    `CHK("lock span", int'(span), i)
    $display("test lock ended, mismatches %0d", errors);
    rt(8'hf4, 1'b1, 1'b0);
    `CHK("halt entry", 2'b10, {halted, fe})
    expq.push_back({1'b1, VEC_NMI});
    np();
    `CHK("nmi wake", 1'b0, halted)
    rt(8'hf4, 1'b1, 1'b0);
    @(posedge mclk) intr_req <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK("masked intr", 1'b1, halted)
    intr_req <= 1'b0;
    repeat (6) @(posedge mclk);
    flt_req <= 1'b1;
    wt(1'b0, 1'b0);
    `CHK("float wake", 1'b0, halted)
    @(posedge mclk) flt_req <= 1'b0;
    $display("test halt ended, mismatches %0d", errors);
    wr(ADR_FLAGS, 32'h202);
    rt(8'hf4, 1'b1, 1'b0);
    expq.push_back({1'b1, ivec});
    @(posedge mclk) intr_req <= 1'b1;
    wt(1'b0, 1'b0);
    `CHK("intr wake", 1'b0, halted)
    wr(ADR_LIMIT, 32'h7f);
    expq.push_back({1'b0, VEC_DBL});
    rt(8'h90, 1'b0, 1'b0);
    wr(ADR_LIMIT, 32'h7);
    rt(8'h90, 1'b0, 1'b0);
    wt(1'b1, 1'b1);
    `CHK("table limit shutdown", 1'b1, shut)
    @(posedge mclk) intr_req <= 1'b0;
    wr(ADR_FLAGS, 32'h2);
    np();
    `CHK("nmi small table", 1'b1, shut)
    @(posedge mclk) sp <= 16'h0005;
    wr(ADR_LIMIT, 32'hff);
    np();
    `CHK("nmi low stack", 1'b1, shut)
    @(posedge mclk) sp <= 16'h0006;
    expq.push_back({1'b1, VEC_NMI});
    np();
    `CHK("nmi exit", 1'b0, shut)
    @(posedge mclk) sp <= 16'h0001;
    rt(8'h50, 1'b0, 1'b1);
    `CHK("odd stack wrap", 1'b1, shut)
    @(posedge mclk) rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("reset exit", 2'b00, {shut, fe})
    rst_b <= 1'b1;
    st();
    rd(ADR_CTRL, 32'h0);
    $display("test shutdown ended, mismatches %0d", errors);
    `CHK("pending exceptions", 0, expq.size())
    conclude();
  end
endmodule // rmx_unit_tb
